// file: osc_switch_map.svh
// Register map, field positions, reset values and timing counts of the oscillator switch control
`ifndef OSC_SWITCH_MAP_SVH
`define OSC_SWITCH_MAP_SVH
`define OSC_CTRL_ADR    8'h00
`define CLK_DIV_ADR     8'h04
`define RC_TUNE_ADR     8'h08
`define CURRENT_SOURCE_FIELD_LSB        12
`define NEW_SOURCE_FIELD_LSB        8
`define SEL_LOCK_BIT    7
`define PLL_LOCK_BIT    5
`define FAIL_BIT        3
`define PSLEEP_BIT      2
`define SECONDARY_OSCILLATOR_EN_BIT     1
`define SWEN_BIT        0
`define ROI_BIT         15
`define DOZE_LSB        12
`define RATIO_ENABLE_BIT       11
`define RC_POSTSCALER_LSB       8
`define USB_BRANCH_POSTSCALER_LSB       6
`define TRIM_LSB        0
`define RC_POSTSCALER_RESET     3'h1
`define KEY_HI_FIRST    8'h78
`define KEY_HI_SECOND   8'h9A
`define KEY_LO_FIRST    8'h46
`define KEY_LO_SECOND   8'h57
`define SETTLE_CYCLES   4'hA
`endif

// file: osc_switch_pkg.sv
// Types shared by the oscillator switch control
package osc_switch_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_READY, ST_SETTLE, ST_DONE} switch_state_type;
  typedef enum logic [1:0] {KEY_NONE, KEY_FIRST, KEY_OPEN} key_state_type;
endpackage : osc_switch_pkg

// file: sync_if.sv
// Carrier between the control block and its input synchroniser bank
`timescale 1ns/100ps
interface sync_if #(parameter int W = 17);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user (output raw, input sync);
endinterface : sync_if

// file: sync_bank.sv
// Two-flop synchroniser bank for pin-level inputs
`timescale 1ns/100ps
module sync_bank #(
  parameter int W = 17
) (
  input  wire logic clk_i,
  sync_if.sync_side p
);
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic hold_r;
      // First flop feeds only the second; no reset, so straps pass while reset is held
      always_ff @(posedge clk_i) begin
        meta_r <= p.raw[i];
        hold_r <= meta_r;
      end
      assign p.sync[i] = hold_r;
    end
  endgenerate
endmodule : sync_bank

// file: osc_switch_ctrl.sv
// Oscillator selection, switching sequence and clock divider control with a Wishbone slave
`timescale 1ns/100ps
`include "osc_switch_map.svh"
module osc_switch_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  switching_config_i,
  input  wire logic [2:0]  reset_source_config_i,
  input  wire logic        pll_lock_i,
  input  wire logic        clock_failure_i,
  input  wire logic        interrupt_i,
  input  wire logic        sleep_i,
  input  wire logic        watchdog_enable_i,
  input  wire logic [3:0]  osc_ready_i,
  input  wire logic [3:0]  osc_clock_i,
  output logic      [3:0]  osc_enable_o,
  output logic             pll_enable_o,
  output logic      [2:0]  system_source_o,
  output logic      [2:0]  cpu_ratio_o,
  output logic      [2:0]  rc_postscaler_o,
  output logic      [1:0]  usb_branch_postscaler_o,
  output logic      [5:0]  rc_trim_o
);
  // Synchronised copies of every pin input
  sync_if #(.W(18)) sv ();
  sync_bank #(.W(18)) u_sync (.clk_i(clk_i), .p(sv.sync_side));
  logic [1:0] cfg_s;
  logic [2:0] strap_s;
  logic       pll_lock_s;
  logic       fail_s;
  logic       int_s;
  logic       sleep_s;
  logic       wdt_s;
  logic [3:0] ready_s;
  logic [3:0] oclk_s;
  assign sv.raw = {switching_config_i, reset_source_config_i, pll_lock_i, clock_failure_i,
                   interrupt_i, sleep_i, watchdog_enable_i, osc_ready_i, osc_clock_i};
  assign {cfg_s, strap_s, pll_lock_s, fail_s, int_s, sleep_s, wdt_s, ready_s, oclk_s} = sv.sync;

  // Source code to oscillator: bit0 primary, bit1 secondary, bit2 fast RC, bit3 low-power RC
  function automatic logic [3:0] src_onehot(input logic [2:0] code);
    case (code)
      3'h2, 3'h3: src_onehot = 4'h1;
      3'h4:       src_onehot = 4'h2;
      3'h5:       src_onehot = 4'h8;
      default:    src_onehot = 4'h4;
    endcase
  endfunction : src_onehot
  function automatic logic uses_pll(input logic [2:0] code);
    uses_pll = (code == 3'h1) || (code == 3'h3);
  endfunction : uses_pll

  // Registers
  osc_switch_pkg::switch_state_type state_r, state_nxt;
  osc_switch_pkg::key_state_type    hkey_r, hkey_nxt, lkey_r, lkey_nxt;
  logic [1:0]  cfg_r;
  logic [2:0]  current_source_field_r, new_source_field_r, tgt_r;
  logic        sel_lock_r, lock_r, fail_r, psleep_r, secondary_oscillator_en_r, swen_r;
  logic        roi_r, ratio_enable_r;
  logic [2:0]  doze_r, rc_postscaler_r;
  logic [1:0]  usb_branch_postscaler_r;
  logic [5:0]  trim_r;
  logic [3:0]  cnt_r;
  logic        oclk_prev_r;
  logic        ack_r;
  logic [31:0] rdat_r;

  // Configuration decode, caught while reset is held
  logic sw_on, fail_safe_monitor_on, sel_locked;
  assign sw_on      = ~cfg_r[1];
  assign fail_safe_monitor_on    = (cfg_r == 2'h0);
  assign sel_locked = fail_safe_monitor_on & sel_lock_r;

  // Bus decode; an access completes at the edge that sees ack high
  logic req, acc, wr, hit_ctl, hit_div, hit_tun, wr_hi, wr_lo;
  logic [7:0] dhi, dlo;
  assign req     = wb_cyc_i & wb_stb_i;
  assign acc     = req & ack_r;
  assign wr      = acc & wb_we_i;
  assign hit_ctl = (wb_adr_i == `OSC_CTRL_ADR);
  assign hit_div = (wb_adr_i == `CLK_DIV_ADR);
  assign hit_tun = (wb_adr_i == `RC_TUNE_ADR);
  assign wr_hi   = wr & hit_ctl & wb_sel_i[1];
  assign wr_lo   = wr & hit_ctl & wb_sel_i[0];
  assign dhi     = wb_dat_i[15:8];
  assign dlo     = wb_dat_i[7:0];

  // Key sequences: any other completed access closes the window
  logic hi_open, lo_open;
  assign hi_open = wr_hi & (hkey_r == osc_switch_pkg::KEY_OPEN);
  assign lo_open = wr_lo & (lkey_r == osc_switch_pkg::KEY_OPEN);
  always_comb begin
    hkey_nxt = hkey_r;
    lkey_nxt = lkey_r;
    if (acc) begin
      hkey_nxt = osc_switch_pkg::KEY_NONE;
      lkey_nxt = osc_switch_pkg::KEY_NONE;
      if (wr_hi && !wb_sel_i[0] && hkey_r == osc_switch_pkg::KEY_NONE && dhi == `KEY_HI_FIRST) begin
        hkey_nxt = osc_switch_pkg::KEY_FIRST;
      end else if (wr_hi && !wb_sel_i[0] && hkey_r == osc_switch_pkg::KEY_FIRST && dhi == `KEY_HI_SECOND) begin
        hkey_nxt = osc_switch_pkg::KEY_OPEN;
      end
      if (wr_lo && !wb_sel_i[1] && lkey_r == osc_switch_pkg::KEY_NONE && dlo == `KEY_LO_FIRST) begin
        lkey_nxt = osc_switch_pkg::KEY_FIRST;
      end else if (wr_lo && !wb_sel_i[1] && lkey_r == osc_switch_pkg::KEY_FIRST && dlo == `KEY_LO_SECOND) begin
        lkey_nxt = osc_switch_pkg::KEY_OPEN;
      end
    end
  end

  // Read data mux; unmapped addresses read zero
  logic [15:0] ctl_rd, div_rd, tun_rd, rd_mux;
  assign ctl_rd = {1'b0, current_source_field_r, 1'b0, new_source_field_r, sel_lock_r, 1'b0, lock_r, 1'b0,
                   fail_r, psleep_r, secondary_oscillator_en_r, swen_r};
  assign div_rd = {roi_r, doze_r, ratio_enable_r, rc_postscaler_r, usb_branch_postscaler_r, 6'h00};
  assign tun_rd = {10'h000, trim_r};
  assign rd_mux = hit_ctl ? ctl_rd : hit_div ? div_rd : hit_tun ? tun_rd : 16'h0000;

  // Switch sequence decode
  logic [3:0] tgt_oh, cur_oh;
  logic busy, same_src, new_ready, oclk_edge, pll_sel;
  assign busy      = (state_r != osc_switch_pkg::ST_IDLE) && (state_r != osc_switch_pkg::ST_CHECK);
  assign tgt_oh    = src_onehot(tgt_r);
  assign cur_oh    = src_onehot(current_source_field_r);
  assign same_src  = (new_source_field_r == current_source_field_r);
  assign pll_sel   = busy ? uses_pll(tgt_r) : uses_pll(current_source_field_r);
  assign new_ready = uses_pll(tgt_r) ? (lock_r & |(ready_s & tgt_oh))
                                     : |(ready_s & tgt_oh);
  assign oclk_edge = |(oclk_s & tgt_oh) & ~oclk_prev_r;

  // Sequence state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      osc_switch_pkg::ST_IDLE:   if (swen_r && sw_on && !sel_locked) state_nxt = osc_switch_pkg::ST_CHECK;
      osc_switch_pkg::ST_CHECK:  state_nxt = same_src ? osc_switch_pkg::ST_IDLE : osc_switch_pkg::ST_READY;
      osc_switch_pkg::ST_READY:  if (new_ready) state_nxt = osc_switch_pkg::ST_SETTLE;
      osc_switch_pkg::ST_SETTLE: if (oclk_edge && cnt_r == `SETTLE_CYCLES - 4'h1) state_nxt = osc_switch_pkg::ST_DONE;
      osc_switch_pkg::ST_DONE:   state_nxt = osc_switch_pkg::ST_IDLE;
      default:                   state_nxt = osc_switch_pkg::ST_IDLE;
    endcase
  end

  logic start_sw;
  assign start_sw = (state_r == osc_switch_pkg::ST_CHECK) && !same_src;

  // Bus handshake: ack one cycle after the request, dropped after one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req & ~ack_r;
      if (req && !ack_r) rdat_r <= {16'h0000, rd_mux};
    end
  end

  // Sequencer state, counter and key tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= osc_switch_pkg::ST_IDLE;
      hkey_r      <= osc_switch_pkg::KEY_NONE;
      lkey_r      <= osc_switch_pkg::KEY_NONE;
      cnt_r       <= 4'h0;
      oclk_prev_r <= 1'b0;
      tgt_r       <= 3'h0;
    end else begin
      state_r     <= state_nxt;
      hkey_r      <= hkey_nxt;
      lkey_r      <= lkey_nxt;
      oclk_prev_r <= |(oclk_s & tgt_oh);
      if (state_r != osc_switch_pkg::ST_SETTLE) cnt_r <= 4'h0;
      else if (oclk_edge) cnt_r <= cnt_r + 4'h1;
      if (start_sw) tgt_r <= new_source_field_r;
    end
  end

  // Strap capture and source fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r  <= cfg_s;
      current_source_field_r <= strap_s;
      new_source_field_r <= strap_s;
    end else begin
      if (state_r == osc_switch_pkg::ST_DONE) current_source_field_r <= tgt_r;
      if (hi_open && sw_on && !sel_locked) new_source_field_r <= dhi[2:0];
    end
  end

  // Oscillator control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_lock_r <= 1'b0;
      lock_r     <= 1'b0;
      fail_r     <= 1'b0;
      psleep_r   <= 1'b0;
      secondary_oscillator_en_r  <= 1'b0;
      swen_r     <= 1'b0;
    end else begin
      lock_r <= start_sw ? 1'b0 : (pll_sel & pll_lock_s);
      if (fail_safe_monitor_on && fail_s) fail_r <= 1'b1;
      else if (start_sw || (lo_open && !dlo[`FAIL_BIT])) fail_r <= 1'b0;
      if (lo_open) begin
        if (dlo[`SEL_LOCK_BIT]) sel_lock_r <= 1'b1;
        psleep_r  <= dlo[`PSLEEP_BIT];
        secondary_oscillator_en_r <= dlo[`SECONDARY_OSCILLATOR_EN_BIT];
      end
      if (!sw_on) swen_r <= 1'b0;
      else if (lo_open && dlo[`SWEN_BIT] && !sel_locked) swen_r <= 1'b1;
      else if ((state_r == osc_switch_pkg::ST_CHECK && same_src) ||
               state_r == osc_switch_pkg::ST_DONE) swen_r <= 1'b0;
    end
  end

  // Divider and trim registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      roi_r   <= 1'b0;
      doze_r  <= 3'h0;
      ratio_enable_r <= 1'b0;
      rc_postscaler_r <= `RC_POSTSCALER_RESET;
      usb_branch_postscaler_r <= 2'h0;
      trim_r  <= 6'h00;
    end else begin
      if (wr && hit_div && wb_sel_i[1]) begin
        roi_r   <= wb_dat_i[`ROI_BIT];
        doze_r  <= wb_dat_i[`DOZE_LSB +: 3];
        ratio_enable_r <= wb_dat_i[`RATIO_ENABLE_BIT];
        rc_postscaler_r <= wb_dat_i[`RC_POSTSCALER_LSB +: 3];
      end
      if (wr && hit_div && wb_sel_i[0]) usb_branch_postscaler_r <= wb_dat_i[`USB_BRANCH_POSTSCALER_LSB +: 2];
      if (roi_r && int_s) ratio_enable_r <= 1'b0;
      if (wr && hit_tun && wb_sel_i[0]) trim_r <= wb_dat_i[`TRIM_LSB +: 6];
    end
  end

  // Oscillator power: current, incoming, and kept-alive sources
  logic [3:0] need;
  assign need = cur_oh | (busy ? tgt_oh : 4'h0)
              | {wdt_s | fail_safe_monitor_on, 1'b0, secondary_oscillator_en_r, 1'b0};

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_enable_o            <= 4'h0;
      pll_enable_o            <= 1'b0;
      system_source_o         <= 3'h0;
      cpu_ratio_o             <= 3'h0;
      rc_postscaler_o         <= 3'h0;
      usb_branch_postscaler_o <= 2'h0;
      rc_trim_o               <= 6'h00;
    end else begin
      osc_enable_o            <= {need[3:1], need[0] & ~(sleep_s & ~psleep_r)};
      pll_enable_o            <= uses_pll(current_source_field_r) | (busy & uses_pll(tgt_r));
      system_source_o         <= current_source_field_r;
      cpu_ratio_o             <= ratio_enable_r ? doze_r : 3'h0;
      rc_postscaler_o         <= rc_postscaler_r;
      usb_branch_postscaler_o <= usb_branch_postscaler_r;
      rc_trim_o               <= trim_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Checks on the switching sequence and control bits
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_swen_held_off: assert property (!sw_on |=> !swen_r)
    else $error("switch enable set while switching disabled");
  a_redundant_abort: assert property (state_r == osc_switch_pkg::ST_CHECK && same_src
    |=> !swen_r && state_r == osc_switch_pkg::ST_IDLE)
    else $error("redundant switch not aborted");
  a_start_clears_lock: assert property (start_sw |=> !lock_r)
    else $error("lock not cleared at switch start");
  a_lock_non_pll: assert property (!pll_sel |=> !lock_r)
    else $error("lock status set in non-PLL mode");
  a_settle_ten: assert property (state_r == osc_switch_pkg::ST_SETTLE && oclk_edge
    && cnt_r == 4'h9 |=> state_r == osc_switch_pkg::ST_DONE)
    else $error("handover not after ten new-clock cycles");
  a_settle_early: assert property (state_r == osc_switch_pkg::ST_DONE |-> $past(cnt_r) == 4'h9)
    else $error("handover before ten new-clock cycles");
  a_done_copy: assert property (state_r == osc_switch_pkg::ST_DONE
    |=> current_source_field_r == $past(tgt_r) && !swen_r)
    else $error("completion did not copy source or clear enable");
  a_doze_recover: assert property (roi_r && int_s |=> !ratio_enable_r ##1 cpu_ratio_o == 3'h0)
    else $error("interrupt did not restore 1:1 ratio");
  a_ratio_forced: assert property (ratio_enable_r |=> cpu_ratio_o == $past(doze_r))
    else $error("ratio output does not follow field");
  a_lock_blocks: assert property (sel_locked && state_r == osc_switch_pkg::ST_IDLE
    |=> state_r == osc_switch_pkg::ST_IDLE)
    else $error("locked selection still switched");
  a_fail_sets: assert property (fail_safe_monitor_on && fail_s |=> fail_r)
    else $error("clock failure not flagged");
  a_key_hi_guard: assert property (wr_hi && hkey_r != osc_switch_pkg::KEY_OPEN |=> $stable(new_source_field_r))
    else $error("unkeyed high byte write took effect");
  a_key_lo_guard: assert property (wr_lo && lkey_r != osc_switch_pkg::KEY_OPEN && !swen_r
    && state_r == osc_switch_pkg::ST_IDLE |=> !swen_r)
    else $error("unkeyed low byte write set switch enable");

  // Checks on outputs, waits and guarded fields
  a_ratio_unity: assert property (!ratio_enable_r |=> cpu_ratio_o == 3'h0)
    else $error("ratio not forced to 1:1 with ratio enable clear");
  a_doze_kept: assert property (!roi_r && ratio_enable_r && !(wr && hit_div && wb_sel_i[1])
    |=> ratio_enable_r)
    else $error("ratio enable lost without recovery");
  a_postscaler_out: assert property (1'b1 |=> rc_postscaler_o == $past(rc_postscaler_r)
    && usb_branch_postscaler_o == $past(usb_branch_postscaler_r))
    else $error("postscaler outputs do not follow fields");
  a_trim_out: assert property (1'b1 |=> rc_trim_o == $past(trim_r))
    else $error("trim output does not follow field");
  a_source_out: assert property (1'b1 |=> system_source_o == $past(current_source_field_r))
    else $error("system source output does not follow current source");
  a_lock_follows: assert property (pll_sel && !start_sw |=> lock_r == $past(pll_lock_s))
    else $error("lock status does not follow PLL lock");
  a_fail_no_monitor: assert property (!fail_safe_monitor_on && !fail_r |=> !fail_r)
    else $error("fail flag set with monitor off");
  a_start_clears_fail: assert property (start_sw && !(fail_safe_monitor_on && fail_s) |=> !fail_r)
    else $error("fail flag not cleared at switch start");
  a_swen_starts: assert property (swen_r && sw_on && !sel_locked
    && state_r == osc_switch_pkg::ST_IDLE |=> state_r == osc_switch_pkg::ST_CHECK)
    else $error("switch request not taken");
  a_wait_ready: assert property (state_r == osc_switch_pkg::ST_READY && !(|(ready_s & tgt_oh))
    |=> state_r == osc_switch_pkg::ST_READY)
    else $error("handover began before new source ready");
  a_wait_lock: assert property (state_r == osc_switch_pkg::ST_READY && uses_pll(tgt_r) && !lock_r
    |=> state_r == osc_switch_pkg::ST_READY)
    else $error("handover began before PLL lock");
  a_sleep_primary_off: assert property (sleep_s && !psleep_r |=> !osc_enable_o[0])
    else $error("primary left on in sleep");
  a_sleep_primary_on: assert property (psleep_r && cur_oh[0] |=> osc_enable_o[0])
    else $error("primary stopped although kept for sleep");
  a_old_rc_off: assert property (state_r == osc_switch_pkg::ST_IDLE && !cur_oh[2]
    |=> !osc_enable_o[2])
    else $error("idle fast RC left powered");
  a_new_source_field_frozen: assert property (!sw_on |=> $stable(new_source_field_r))
    else $error("new source changed while switching disabled");
  a_key_hi_write: assert property (hi_open && sw_on && !sel_locked |=> new_source_field_r == $past(dhi[2:0]))
    else $error("keyed high byte write not taken");
endmodule : osc_switch_ctrl

// file: tb_osc_switch_ctrl.sv
// Self-checking bench for the oscillator switch control block
`timescale 1ns/100ps
`include "osc_switch_map.svh"
module tb_osc_switch_ctrl;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pll_enable_o;
  logic        pll_lock_i, clock_failure_i, interrupt_i, sleep_i, watchdog_enable_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, osc_ready_i, osc_clock_i, osc_enable_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0]  switching_config_i, usb_branch_postscaler_o;
  logic [2:0]  reset_source_config_i, system_source_o, cpu_ratio_o, rc_postscaler_o, c;
  logic [5:0]  rc_trim_o;
  logic [5:0]  trims [3];
  int          n_errors, check_count, cyc_n, t0;

  osc_switch_ctrl osc_switch_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .switching_config_i(switching_config_i),
    .reset_source_config_i(reset_source_config_i), .pll_lock_i(pll_lock_i),
    .clock_failure_i(clock_failure_i), .interrupt_i(interrupt_i), .sleep_i(sleep_i),
    .watchdog_enable_i(watchdog_enable_i), .osc_ready_i(osc_ready_i), .osc_clock_i(osc_clock_i),
    .osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o), .system_source_o(system_source_o),
    .cpu_ratio_o(cpu_ratio_o), .rc_postscaler_o(rc_postscaler_o),
    .usb_branch_postscaler_o(usb_branch_postscaler_o), .rc_trim_o(rc_trim_o)
  );

  // 25 MHz system clock
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end

  // Oscillator clocks at half the system rate, cycle counter
  always @(posedge clk_i) begin
    osc_clock_i <= ~osc_clock_i;
    cyc_n       <= cyc_n + 1;
  end

  // Verdict and end of run
  task stop_test;
    $display("Counts: %0d compares, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle, read data left in rd
  task bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      stop_test();
    end
  endtask : bus

  task rchk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp, input string msg);
    bus(1'h0, adr, 4'h3, 32'h0);
    chk(rd & mask, exp, msg);
  endtask : rchk

  // Keyed writes to the control high and low bytes
  task unlock_hi(input logic [2:0] src);
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, 32'h7800);
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, 32'h9A00);
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, {21'h0, src, 8'h00});
  endtask : unlock_hi

  task unlock_lo(input logic [7:0] v);
    bus(1'h1, `OSC_CTRL_ADR, 4'h1, 32'h0046);
    bus(1'h1, `OSC_CTRL_ADR, 4'h1, 32'h0057);
    bus(1'h1, `OSC_CTRL_ADR, 4'h1, {24'h0, v});
  endtask : unlock_lo

  // Poll switch enable until it clears, bounded to 60 reads
  task wait_sw;
    int k;
    k = 0;
    do begin
      bus(1'h0, `OSC_CTRL_ADR, 4'h3, 32'h0);
      k++;
    end while (rd[0] !== 1'h0 && k < 60);
    if (k >= 60) begin
      n_errors++;
      $display("CHECK FAILED at %0t: switch never completed", $time);
      stop_test();
    end
  endtask : wait_sw

  task pulse_fail;
    @(posedge clk_i);
    clock_failure_i <= 1'h1;
    @(posedge clk_i);
    clock_failure_i <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask : pulse_fail

  // Main sequence
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    switching_config_i = 2'h0;
    reset_source_config_i = 3'h7;
    {pll_lock_i, clock_failure_i, interrupt_i, sleep_i, watchdog_enable_i} = 5'h10;
    osc_ready_i = 4'hF;
    osc_clock_i = 4'h0;
    cyc_n = 0;
    n_errors = 0;
    check_count = 0;
    trims = '{6'h1F, 6'h20, 6'h3F};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    rchk(`OSC_CTRL_ADR, 32'hFFFF_FFFF, 32'h0000_7700, "control reset, lock low");
    rchk(`CLK_DIV_ADR, 32'hFFFF_FFFF, 32'h0000_0100, "divider reset");
    rchk(`RC_TUNE_ADR, 32'hFFFF_FFFF, 32'h0000_0000, "tune reset");
    rchk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    $display("Test reset values done");
    // Every ratio, postscaler and branch code
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      bus(1'h1, `CLK_DIV_ADR, 4'h3, {16'h0, 1'h0, c, 1'h1, c, c[1:0], 6'h3F});
      rchk(`CLK_DIV_ADR, 32'hFFFF_FFFF, {16'h0, 1'h0, c, 1'h1, c, c[1:0], 6'h00}, "divider readback");
      chk(cpu_ratio_o, c, "cpu ratio");
      chk(rc_postscaler_o, c, "rc postscaler");
      chk(usb_branch_postscaler_o, c[1:0], "usb postscaler");
    end
    bus(1'h1, `CLK_DIV_ADR, 4'h3, 32'h0000_5000);
    rchk(`CLK_DIV_ADR, 32'hFFFF, 32'h5000, "ratio disabled");
    chk(cpu_ratio_o, 3'h0, "ratio forced 1:1");
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, `RC_TUNE_ADR, 4'h3, {16'h0, 10'h3FF, trims[i]});
      rchk(`RC_TUNE_ADR, 32'hFFFF_FFFF, {26'h0, trims[i]}, "trim readback");
      chk(rc_trim_o, trims[i], "trim output");
    end
    $display("Test divider and tune done");
    // Interrupt with and without recovery
    for (int i = 0; i < 2; i++) begin
      bus(1'h1, `CLK_DIV_ADR, 4'h3, {16'h0, i[0], 15'h7800});
      @(posedge clk_i);
      interrupt_i <= 1'h1;
      @(posedge clk_i);
      interrupt_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      rchk(`CLK_DIV_ADR, 32'hFFFF, {16'h0, i[0], 3'h7, ~i[0], 11'h0}, "ratio enable after irq");
      chk(cpu_ratio_o, i[0] ? 3'h0 : 3'h7, "ratio after irq");
    end
    $display("Test interrupt recovery done");
    // Unkeyed and broken-key writes are dropped
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, 32'h0300);
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, 32'h7800);
    bus(1'h0, `CLK_DIV_ADR, 4'h3, 32'h0);
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, 32'h9A00);
    bus(1'h1, `OSC_CTRL_ADR, 4'h2, 32'h0300);
    bus(1'h1, `OSC_CTRL_ADR, 4'h1, 32'h0001);
    rchk(`OSC_CTRL_ADR, 32'h0701, 32'h0700, "unkeyed writes ignored");
    $display("Test write protection done");
    // Fail flag set by monitor, cleared by software
    pulse_fail();
    rchk(`OSC_CTRL_ADR, 32'h0008, 32'h0008, "fail flag set");
    unlock_lo(8'h00);
    rchk(`OSC_CTRL_ADR, 32'h0008, 32'h0000, "fail flag cleared");
    pulse_fail();
    $display("Test fail flag done");
    // Switch to primary with PLL, lock held off at first; never PLL to PLL directly
    @(posedge clk_i);
    pll_lock_i <= 1'h0;
    unlock_hi(3'h3);
    rchk(`OSC_CTRL_ADR, 32'h0708, 32'h0308, "new source written, fail still set");
    unlock_lo(8'h09);
    repeat (30) @(posedge clk_i);
    rchk(`OSC_CTRL_ADR, 32'h7001, 32'h7001, "waits for pll lock");
    @(posedge clk_i);
    pll_lock_i <= 1'h1;
    t0 = cyc_n;
    wait_sw();
    chk(32'(cyc_n - t0 >= 20), 32'h1, "ten new-clock cycles of settle");
    rchk(`OSC_CTRL_ADR, 32'h772D, 32'h3320, "switch done, lock up, fail clear");
    chk(system_source_o, 3'h3, "system source");
    chk({osc_enable_o[3], osc_enable_o[2], osc_enable_o[0], pll_enable_o}, 4'hB, "enables");
    $display("Test clock switch done");
    // Primary in sleep
    @(posedge clk_i);
    sleep_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk(osc_enable_o[0], 1'h0, "primary off in sleep");
    unlock_lo(8'h06);
    repeat (4) @(posedge clk_i);
    chk(osc_enable_o[0], 1'h1, "primary kept in sleep");
    chk(osc_enable_o, 4'hB, "secondary kept by its enable");
    sleep_i <= 1'h0;
    $display("Test sleep done");
    // Redundant switch is abandoned quickly
    unlock_hi(3'h3);
    t0 = cyc_n;
    unlock_lo(8'h01);
    wait_sw();
    chk(32'(cyc_n - t0 < 20), 32'h1, "equal sources abort");
    rchk(`OSC_CTRL_ADR, 32'h7001, 32'h3000, "source unchanged");
    // Selection lock blocks further changes
    unlock_lo(8'h80);
    rchk(`OSC_CTRL_ADR, 32'h0080, 32'h0080, "lock set");
    unlock_hi(3'h0);
    rchk(`OSC_CTRL_ADR, 32'h0700, 32'h0300, "new source locked");
    unlock_lo(8'h81);
    repeat (4) @(posedge clk_i);
    rchk(`OSC_CTRL_ADR, 32'h7001, 32'h3000, "switch start locked");
    $display("Test abort and lock done");
    // Switching disabled by the configuration straps
    @(posedge clk_i);
    rst_i <= 1'h1;
    switching_config_i <= 2'h2;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    unlock_hi(3'h0);
    unlock_lo(8'h01);
    repeat (30) @(posedge clk_i);
    rchk(`OSC_CTRL_ADR, 32'h7001, 32'h7000, "switching disabled");
    chk(system_source_o, 3'h7, "reset source kept");
    $display("Test switching disabled done");
    stop_test();
  end
endmodule : tb_osc_switch_ctrl
